// >>> design/spio_pad_mux.sv
// Per-pin pad ownership multiplexer pair
module spio_pad_mux (
   input  wire logic i_periph_drive,
   input  wire logic i_periph_data,
   input  wire logic i_dir_in,
   input  wire logic i_latch,
   output logic      o_pad_out,
   output logic      o_pad_oe
);
   // =====================================================
   // Peripheral wins; port uses latch when direction is output
   assign o_pad_out = i_periph_drive ? i_periph_data : i_latch;
   assign o_pad_oe  = i_periph_drive | ~i_dir_in;
endmodule : spio_pad_mux

// >>> design/spio_pkg.sv
// Package of constants for the shared parallel I/O port
// Overview of operation
// - Every pin except supply, master clear and primary oscillator input is reachable by a port bit and peripherals.
// - A pin that an enabled peripheral is actively driving is not used as a port output.
// - While a peripheral drives a pin the port driver is off, yet the pin level stays readable.
// - An enabled peripheral that is not actively driving a pin leaves that pin to the port latch.
// - Per pin, two multiplexers pick peripheral or port for pad data and enable, peripheral first.
// - A direction bit of one makes the pin an input with the port driver released.
// - Reset sets every direction bit so all pins come up as inputs.
// - Reading the latch register returns the latch, and writing it updates the latch.
// - Reading the pin-value register returns the sampled pins, and writing it stores into the latch.
// - Bits absent on a variant read as zero in latch, direction and pin-value registers.
// - A pin shared only with input functions behaves as a dedicated port pin.
package spio_pkg;
   // =====================================================
   // Register offsets
   localparam logic [3:0] SPIO_PIN_DIRECTION_REG = 4'h0;
   localparam logic [3:0] SPIO_OUTPUT_LATCH_REG  = 4'h2;
   localparam logic [3:0] SPIO_PIN_VALUE_REG     = 4'h4;
   // =====================================================
   // Reset values and port width
   localparam logic [15:0] SPIO_DIR_RESET   = 16'hffff;
   localparam logic [15:0] SPIO_LATCH_RESET = 16'h0000;
   localparam logic [15:0] SPIO_PORT_WIDTH  = 16'h0010;
endpackage : spio_pkg

// >>> design/spio_port.sv
// Shared parallel I/O port top level
module spio_port #(
   parameter int          WIDTH      = 16,
   parameter logic [15:0] VALID_MASK = 16'hffff
) (
   input  wire logic             I_CLK,
   input  wire logic             I_SRST,
   input  wire logic [3:0]       I_ADDR,
   input  wire logic [15:0]      I_WDATA,
   input  wire logic             I_WR,
   input  wire logic             I_RD,
   output logic      [15:0]      O_RDATA,
   input  wire logic [WIDTH-1:0] I_PAD_IN,
   output logic      [WIDTH-1:0] O_PAD_OUT,
   output logic      [WIDTH-1:0] O_PAD_OE,
   input  wire logic [WIDTH-1:0] I_PERIPH_DRIVE,
   input  wire logic [WIDTH-1:0] I_PERIPH_DATA,
   output logic      [WIDTH-1:0] O_PIN_LEVEL
);
   logic [WIDTH-1:0] mask;
   logic [WIDTH-1:0] dir_q;
   logic [WIDTH-1:0] latch_q;
   logic [WIDTH-1:0] pad_s1_q;
   logic [WIDTH-1:0] pad_s2_q;
   logic [WIDTH-1:0] pad_out_d;
   logic [WIDTH-1:0] pad_oe_d;
   logic [15:0]      rdata_d;
   logic             wr_dir;
   logic             wr_lat;
   logic [WIDTH-1:0] dir_rd;
   logic [WIDTH-1:0] lat_rd;
   logic [WIDTH-1:0] pin_rd;

   // =====================================================
   // Decode; latch and pin-value writes both land in the latch
   assign mask   = VALID_MASK[WIDTH-1:0];
   assign wr_dir = I_WR && (I_ADDR == spio_pkg::SPIO_PIN_DIRECTION_REG);
   assign wr_lat = I_WR && (I_ADDR == spio_pkg::SPIO_OUTPUT_LATCH_REG
                         || I_ADDR == spio_pkg::SPIO_PIN_VALUE_REG);
   // Absent bits read as zero everywhere
   assign dir_rd = dir_q & mask;
   assign lat_rd = latch_q & mask;
   assign pin_rd = pad_s2_q & mask;
   always_comb begin
      rdata_d = 16'h0000;
      if (I_RD) begin
         unique case (I_ADDR)
            spio_pkg::SPIO_PIN_DIRECTION_REG: rdata_d[WIDTH-1:0] = dir_rd;
            spio_pkg::SPIO_OUTPUT_LATCH_REG:  rdata_d[WIDTH-1:0] = lat_rd;
            spio_pkg::SPIO_PIN_VALUE_REG:     rdata_d[WIDTH-1:0] = pin_rd;
            default:                          rdata_d = 16'h0000;
         endcase
      end
   end

   // =====================================================
   // Control registers; reset makes every pin an input
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         dir_q   <= spio_pkg::SPIO_DIR_RESET[WIDTH-1:0];
         latch_q <= spio_pkg::SPIO_LATCH_RESET[WIDTH-1:0];
      end else begin
         if (wr_dir) begin
            dir_q <= I_WDATA[WIDTH-1:0] | ~mask;                     // absent bits stay inputs
         end
         if (wr_lat) begin
            latch_q <= I_WDATA[WIDTH-1:0] & mask;
         end
      end
   end

   // =====================================================
   // Pad input synchroniser, pins are asynchronous
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         pad_s1_q <= '0;
         pad_s2_q <= '0;
      end else begin
         pad_s1_q <= I_PAD_IN;
         pad_s2_q <= pad_s1_q;
      end
   end

   // =====================================================
   // One mux pair per pin; present pins get port and peripheral paths, absent pins neither
   for (genvar g = 0; g < WIDTH; g++) begin : g_pin
      spio_pad_mux u_mux (
         .i_periph_drive (I_PERIPH_DRIVE[g] & mask[g]),
         .i_periph_data  (I_PERIPH_DATA[g]),
         .i_dir_in       (dir_q[g] | ~mask[g]),
         .i_latch        (latch_q[g]),
         .o_pad_out      (pad_out_d[g]),
         .o_pad_oe       (pad_oe_d[g])
      );
   end

   // =====================================================
   // Registered outputs; costs a cycle of pad latency
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_PAD_OUT   <= '0;
         O_PAD_OE    <= '0;
         O_RDATA     <= 16'h0000;
         O_PIN_LEVEL <= '0;
      end else begin
         O_PAD_OUT   <= pad_out_d;
         O_PAD_OE    <= pad_oe_d;
         O_RDATA     <= rdata_d;
         O_PIN_LEVEL <= pin_rd;
      end
   end
endmodule : spio_port

// >>> test/spio_pad_world.sv
// Pad-side model of the pins
module spio_pad_world #(parameter int WIDTH = 16) (
   input wire logic [WIDTH-1:0] i_pad_out, i_pad_oe, i_ext,
   output logic [WIDTH-1:0] o_pad_in);
   timeunit 1ns; timeprecision 1ps;
   // Undriven pins show the outside level, never a stale value
   assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
endmodule : spio_pad_world

// >>> test/spio_port_properties.sv
// Pad ownership and readback checks
module spio_port_props #(parameter int WIDTH = 16, parameter logic [15:0] VALID_MASK = 16'hffff) (
   input wire logic I_CLK, I_SRST, I_RD, input wire logic [3:0] I_ADDR, input wire logic [15:0] O_RDATA,
   input wire logic [WIDTH-1:0] I_PAD_IN, O_PAD_OUT, O_PAD_OE, I_PERIPH_DRIVE, I_PERIPH_DATA, O_PIN_LEVEL);
   timeunit 1ns; timeprecision 1ps;
   // Absent bits count only where checked to stay zero
   wire [WIDTH-1:0] m = VALID_MASK[WIDTH-1:0];
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SRST);
   // Pins need sync time first
   sequence pads_still; $stable(I_PAD_IN)[*5]; endsequence
   a_periph_oe: assert property (!$past(I_SRST) |->
      (O_PAD_OE | ~$past(I_PERIPH_DRIVE) | ~m) == '1) else $error("oe");
   a_periph_data: assert property (!$past(I_SRST) |->
      ((O_PAD_OUT ^ $past(I_PERIPH_DATA)) & $past(I_PERIPH_DRIVE) & m) == '0) else $error("out");
   a_reset_inputs: assert property ($past(I_SRST) |-> O_PAD_OE == '0) else $error("rst");
   a_absent_zero: assert property (((O_PAD_OE | O_PIN_LEVEL) & ~m) == '0) else $error("absent");
   a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == '0) else $error("idle");
   a_unmapped_zero: assert property ($past(I_RD) && !($past(I_ADDR) inside {4'h0, 4'h2, 4'h4}) |->
      O_RDATA == '0) else $error("map");
   a_pins_follow: assert property (pads_still |-> O_PIN_LEVEL == (I_PAD_IN & m)) else $error("pin");
   a_pin_read: assert property ((pads_still ##0 I_RD && I_ADDR == 4'h4) |=>
      O_RDATA[WIDTH-1:0] == ($past(I_PAD_IN) & m)) else $error("prd");
endmodule : spio_port_props

// >>> test/spio_port_tb.sv
// Bench for the shared port
module spio_port_tb;
   timeunit 1ns; timeprecision 1ps;
   logic clk = 0, srst = 1, wr = 0, rd = 0;
   logic [3:0] addr = '0;
   logic [15:0] wd = '0, rdat, pout, poe, drv = '0, pdat = '0, ext = 16'h5a5a, pin, lvl;
   int error_cnt = 0, n_checks = 0;
   spio_port #(.WIDTH(16), .VALID_MASK(16'h7fff)) dut (.I_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wd),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE(poe),
      .I_PERIPH_DRIVE(drv), .I_PERIPH_DATA(pdat), .O_PIN_LEVEL(lvl));
   spio_pad_world world (.i_pad_out(pout), .i_pad_oe(poe), .i_ext(ext), .o_pad_in(pin));
   initial forever #2 clk = ~clk;
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin error_cnt++; $display("[ERR] %s expected %h seen %h", s, e, g); end
   endtask : chk
   task automatic wr16(logic [3:0] a, logic [15:0] d);
      @(posedge clk) begin addr <= a; wd <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask : wr16
   // Read data stands only in the cycle after the strobe
   task automatic rdchk(logic [3:0] a, logic [15:0] e);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 chk("rdata", e, rdat);
   endtask : rdchk
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task automatic t_port;
      rdchk(4'h0, 16'h7fff);
      chk("oe", 16'h0000, poe);
      wr16(4'h0, 16'h0000);
      wr16(4'h2, 16'ha5a5);
      rdchk(4'h2, 16'h25a5);
      chk("oe", 16'h7fff, poe);
      chk("out", 16'h25a5, pout & 16'h7fff);
      repeat (3) @(posedge clk);
      rdchk(4'h4, 16'h25a5);
      wr16(4'h4, 16'h1234);
      rdchk(4'h2, 16'h1234);
      rdchk(4'h6, 16'h0000);
      $display("port test done");
   endtask : t_port
   task automatic t_periph;
      @(posedge clk) begin drv <= 16'h00ff; pdat <= 16'h0f0f; end
      repeat (5) @(posedge clk);
      chk("out", 16'h120f, pout & 16'h7fff);
      rdchk(4'h2, 16'h1234);
      rdchk(4'h4, 16'h120f);
      wr16(4'h0, 16'hffff);
      repeat (4) @(posedge clk);
      chk("oe", 16'h00ff, poe);
      rdchk(4'h4, 16'h5a0f);
      chk("level", 16'h5a0f, lvl);
      @(posedge clk) drv <= 16'h0000;
      wr16(4'h0, 16'h0000);
      #1 chk("out", 16'h1234, pout & 16'h7fff);
      // Enable follows the direction write one edge later
      @(posedge clk) #1 chk("oe", 16'h7fff, poe);
      $display("periph test done");
   endtask : t_periph
   // Whole run is under fifty cycles
   initial begin #20000; error_cnt++; conclude; end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_port;
      t_periph;
      conclude;
   end
endmodule : spio_port_tb
bind spio_port spio_port_props #(.WIDTH(WIDTH), .VALID_MASK(VALID_MASK)) u_props (.I_CLK(I_CLK), .I_SRST(I_SRST),
   .I_RD(I_RD), .I_ADDR(I_ADDR), .O_RDATA(O_RDATA), .I_PAD_IN(I_PAD_IN), .O_PAD_OUT(O_PAD_OUT), .O_PAD_OE(O_PAD_OE),
   .I_PERIPH_DRIVE(I_PERIPH_DRIVE), .I_PERIPH_DATA(I_PERIPH_DATA), .O_PIN_LEVEL(O_PIN_LEVEL));
